// *** rtl/cic_core.sv ***
// Purpose: Core interrupt control with flags, enables and pin-change detect.
// Assumes: All inputs synchronous to ref_clk; APB slave with zero wait states.
// Notes:   Flags set over clear in the same cycle; one level irq to the core.
//          Unmapped offsets answer with an error.
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/10ps
`include "cic_cfg.svh"

// Operation
// - Global enable gates every core request
// - Flags set regardless of any request enable; pin flags need an edge enable
// - External pin enable gates its request
// - Change enable gates summary flag request
// - Timer overflow sets timer flag
// - External pin event sets its flag
// - Summary flag reflects any per-pin flag
// - Summary flag read-only, clears with pins
// - Rise enable detects rising pin edges
// - Fall enable detects falling pin edges
// - Detected edge sets pin and summary
// - Both enables off records no change
// - Unimplemented edge-enable bits read zero
module cic_core
    import cic_pkg::*;
(
    input  wire logic                ref_clk,        // System clock
    input  wire logic                rst_n,          // Async reset, low
    input  wire logic                psel,           // APB select
    input  wire logic                penable,        // APB enable
    input  wire logic                pwrite,         // APB direction
    input  wire logic [11:0]         paddr,          // APB byte address
    input  wire cic_pkg::cic_word_type pwdata,       // APB write data
    input  wire logic [3:0]          pstrb,          // APB byte strobes
    output logic                     pready,         // APB ready
    output cic_pkg::cic_word_type    prdata,         // APB read data
    output logic                     pslverr,        // APB error
    input  wire logic                timer_overflow, // Timer wrap pulse
    input  wire logic                ext_pin_event,  // External pin event pulse
    input  wire logic                port_e3_pin,    // Port E pin 3 level
    input  wire logic [7:0]          periph_event,   // Peripheral event pulses
    output logic                     core_irq,       // Request to core
    output logic                     irq             // Masked status irq
);
    import cic_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // Core enables and flags
    logic [7:0] ctrl_q,   ctrl_d;       // Enable bits; flags kept apart
    logic       timer_overflow_flag_q, timer_overflow_flag_d;
    logic       ext_pin_irq_flag_q,    ext_pin_irq_flag_d;

    // Port E edge enables and change flags
    logic [7:0] port_e_change_flag_q,  port_e_change_flag_d;
    logic       port_e3_rise_detect_enable_q, port_e3_rise_detect_enable_d;
    logic       port_e3_fall_detect_enable_q, port_e3_fall_detect_enable_d;

    // Peripheral sources
    logic [7:0] periph_flag_q, periph_flag_d;
    logic [7:0] periph_en_q,   periph_en_d;

    // Status and mask per event class
    logic [2:0] stat_q, stat_d;
    logic [2:0] mask_q, mask_d;

    // Pin history for edge detect
    logic       pin_q,  pin_d;

    // Output and bus answer registers
    logic       core_irq_q, core_irq_d;
    logic       irq_q,  irq_d;
    cic_word_type prdata_q, prdata_d;
    logic       pready_q, pready_d;
    logic       pslverr_q, pslverr_d;

    // Decode and detection nets
    logic       wr_en;
    logic       rd_en;
    logic       hit;
    logic       rise_edge;
    logic       fall_edge;
    logic       pin_change_summary_flag;
    logic [7:0] wbyte;
    logic [7:0] control_view;

    // Low byte of write data, honouring the strobe
    function automatic logic [7:0] wr_low(input logic [7:0] old,
                                          input cic_word_type d,
                                          input logic s);
        wr_low = s ? d[7:0] : old;
    endfunction : wr_low


    // One-to-clear with a simultaneous set winning
    // Hazard: a clear racing an event must not lose it
    function automatic logic w1c(input logic cur, input logic set,
                                 input logic clr);
        w1c = set | (cur & ~clr);
    endfunction : w1c

    // ------------------------------------------------------------------
    // Decode and detection
    // ------------------------------------------------------------------
    // Write lands at the access edge, while ready stands
    assign wr_en = psel & penable & pwrite & pready_q;
    // Read captured in setup so it stands with ready
    assign rd_en = psel & ~penable & ~pwrite;
    // Only the low byte carries fields
    assign wbyte = pwdata[7:0];

    assign rise_edge = port_e3_pin & ~pin_q & port_e3_rise_detect_enable_q;
    assign fall_edge = ~port_e3_pin & pin_q & port_e3_fall_detect_enable_q;
    assign pin_change_summary_flag = |port_e_change_flag_q;
    // Control byte as software sees it
    assign control_view = {ctrl_q[7:3], timer_overflow_flag_q,
                           ext_pin_irq_flag_q, pin_change_summary_flag};

    // A miss answers with an error and writes nothing
    always_comb
    begin
        case (paddr)
            `CIC_OFS_INTERRUPT_CONTROL,
            `CIC_OFS_RISE_ENABLE,
            `CIC_OFS_FALL_ENABLE,
            `CIC_OFS_CHANGE_FLAG,
            `CIC_OFS_PERIPH_FLAG,
            `CIC_OFS_PERIPH_ENABLE,
            `CIC_OFS_IRQ_STATUS,
            `CIC_OFS_IRQ_MASK: hit = 1'b1;
            default:           hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Register and flag next state
    // ------------------------------------------------------------------
    always_comb
    begin
        ctrl_d                       = ctrl_q;
        port_e3_rise_detect_enable_d = port_e3_rise_detect_enable_q;
        port_e3_fall_detect_enable_d = port_e3_fall_detect_enable_q;
        periph_en_d                  = periph_en_q;
        mask_d                       = mask_q;
        // History follows the pin each clock
        pin_d                        = port_e3_pin;
        timer_overflow_flag_d = timer_overflow | timer_overflow_flag_q;
        ext_pin_irq_flag_d    = ext_pin_event | ext_pin_irq_flag_q;
        port_e_change_flag_d  = port_e_change_flag_q;
        port_e_change_flag_d[`CIC_BIT_PORT_E3] =
            port_e_change_flag_q[`CIC_BIT_PORT_E3] | rise_edge | fall_edge;
        // Peripheral flags set from pulses
        periph_flag_d = periph_flag_q | periph_event;
        // Status set on every timer, external pin and pin-change event, masked or not; peripheral events have no status bit
        stat_d = stat_q;
        stat_d[`CIC_EVT_TIMER]  = stat_q[`CIC_EVT_TIMER] | timer_overflow;
        stat_d[`CIC_EVT_EXT]    = stat_q[`CIC_EVT_EXT] | ext_pin_event;
        stat_d[`CIC_EVT_CHANGE] = stat_q[`CIC_EVT_CHANGE] | rise_edge | fall_edge;
        // Only the low strobe lets a write land
        if (wr_en && pstrb[0])
        begin
            case (paddr)
                `CIC_OFS_INTERRUPT_CONTROL:
                begin
                    ctrl_d = {wbyte[7:3], 3'b000};
                    // Flags clear by writing zero; an event still wins
                    timer_overflow_flag_d = timer_overflow |
                        (timer_overflow_flag_q & wbyte[`CIC_BIT_TIMER_FLAG]);
                    ext_pin_irq_flag_d = ext_pin_event |
                        (ext_pin_irq_flag_q & wbyte[`CIC_BIT_EXT_FLAG]);
                end
                `CIC_OFS_RISE_ENABLE: port_e3_rise_detect_enable_d = wbyte[`CIC_BIT_PORT_E3];
                `CIC_OFS_FALL_ENABLE: port_e3_fall_detect_enable_d = wbyte[`CIC_BIT_PORT_E3];
                `CIC_OFS_CHANGE_FLAG:
                begin
                    port_e_change_flag_d[`CIC_BIT_PORT_E3] = rise_edge | fall_edge |
                        (port_e_change_flag_q[`CIC_BIT_PORT_E3] & wbyte[`CIC_BIT_PORT_E3]);
                end
                // Cleared by writing zero
                `CIC_OFS_PERIPH_FLAG:   periph_flag_d = periph_event | (periph_flag_q & wbyte);
                `CIC_OFS_PERIPH_ENABLE: periph_en_d = wr_low(periph_en_q, pwdata, 1'b1);
                `CIC_OFS_IRQ_STATUS:
                begin
                    // Write one clears; an event wins
                    stat_d[`CIC_EVT_TIMER]  = w1c(stat_q[`CIC_EVT_TIMER], timer_overflow,
                                                  wbyte[`CIC_EVT_TIMER]);
                    stat_d[`CIC_EVT_EXT]    = w1c(stat_q[`CIC_EVT_EXT], ext_pin_event,
                                                  wbyte[`CIC_EVT_EXT]);
                    stat_d[`CIC_EVT_CHANGE] = w1c(stat_q[`CIC_EVT_CHANGE],
                                                  rise_edge | fall_edge,
                                                  wbyte[`CIC_EVT_CHANGE]);
                end
                // Only three event classes
                `CIC_OFS_IRQ_MASK: mask_d = wbyte[2:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs and bus answer
    // ------------------------------------------------------------------
    always_comb
    begin
        // Registered: one cycle behind the flags
        // request gating
        core_irq_d = ctrl_q[`CIC_BIT_GLOBAL_EN] &
            ((ctrl_q[`CIC_BIT_TIMER_EN] & timer_overflow_flag_q) |
             (ctrl_q[`CIC_BIT_EXT_EN] & ext_pin_irq_flag_q) |
             (ctrl_q[`CIC_BIT_CHANGE_EN] & pin_change_summary_flag) |
             (ctrl_q[`CIC_BIT_PERIPH_EN] & (|(periph_flag_q & periph_en_q))));
        // Status irq: OR of masked bits
        irq_d      = |(stat_q & mask_q);
        // Zero-wait access; ready raised in setup so access ends at once
        pready_d   = psel & ~penable;
        // Error only for a miss, with ready
        pslverr_d  = psel & ~penable & ~hit;
        // Read data holds between reads
        prdata_d   = prdata_q;
        // Read mux; upper bits read zero
        if (rd_en)
        begin
            case (paddr)
                `CIC_OFS_INTERRUPT_CONTROL: prdata_d = {24'h000000, control_view};
                `CIC_OFS_RISE_ENABLE: prdata_d = {28'h0000000,
                                                  port_e3_rise_detect_enable_q, 3'h0};
                `CIC_OFS_FALL_ENABLE: prdata_d = {28'h0000000,
                                                  port_e3_fall_detect_enable_q, 3'h0};
                `CIC_OFS_CHANGE_FLAG:   prdata_d = {24'h000000, port_e_change_flag_q};
                `CIC_OFS_PERIPH_FLAG:   prdata_d = {24'h000000, periph_flag_q};
                `CIC_OFS_PERIPH_ENABLE: prdata_d = {24'h000000, periph_en_q};
                `CIC_OFS_IRQ_STATUS:    prdata_d = {29'h0, stat_q};
                `CIC_OFS_IRQ_MASK:      prdata_d = {29'h0, mask_q};
                default:                prdata_d = 32'h00000000;
            endcase
        end
    end

    // Register everything; reset to constants only
    // Pin history resets low; enables too, so no false edge
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q                       <= `CIC_RST_CONTROL;
            timer_overflow_flag_q        <= 1'b0;
            ext_pin_irq_flag_q           <= 1'b0;
            port_e_change_flag_q         <= 8'h00;
            port_e3_rise_detect_enable_q <= 1'b0;
            port_e3_fall_detect_enable_q <= 1'b0;
            periph_flag_q                <= 8'h00;
            periph_en_q                  <= 8'h00;
            stat_q                       <= 3'h0;
            mask_q                       <= 3'h0;
            pin_q                        <= 1'b0;
            core_irq_q                   <= 1'b0;
            irq_q                        <= 1'b0;
            prdata_q                     <= 32'h00000000;
            pready_q                     <= 1'b0;
            pslverr_q                    <= 1'b0;
        end
        else
        begin
            ctrl_q                       <= ctrl_d;
            timer_overflow_flag_q        <= timer_overflow_flag_d;
            ext_pin_irq_flag_q           <= ext_pin_irq_flag_d;
            port_e_change_flag_q         <= port_e_change_flag_d;
            port_e3_rise_detect_enable_q <= port_e3_rise_detect_enable_d;
            port_e3_fall_detect_enable_q <= port_e3_fall_detect_enable_d;
            periph_flag_q                <= periph_flag_d;
            periph_en_q                  <= periph_en_d;
            stat_q                       <= stat_d;
            mask_q                       <= mask_d;
            pin_q                        <= pin_d;
            core_irq_q                   <= core_irq_d;
            irq_q                        <= irq_d;
            prdata_q                     <= prdata_d;
            pready_q                     <= pready_d;
            pslverr_q                    <= pslverr_d;
        end
    end

    // Each output straight from its register
    assign core_irq = core_irq_q;
    assign irq      = irq_q;
    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;

endmodule : cic_core

// *** rtl/cic_cfg.svh ***
// Purpose: Offsets, field positions and reset values of the interrupt control block.
// Assumes: APB with 32-bit data, one aligned word for each register.
// Notes:   Definitions only.
`ifndef CIC_CFG_SVH
`define CIC_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CIC_OFS_INTERRUPT_CONTROL 12'h000
`define CIC_OFS_RISE_ENABLE       12'h004
`define CIC_OFS_FALL_ENABLE       12'h008
`define CIC_OFS_CHANGE_FLAG       12'h00C
`define CIC_OFS_PERIPH_FLAG       12'h010
`define CIC_OFS_PERIPH_ENABLE     12'h014
`define CIC_OFS_IRQ_STATUS        12'h018
`define CIC_OFS_IRQ_MASK          12'h01C

// ----------------------------------------------------------------------
// Interrupt control fields
// ----------------------------------------------------------------------
`define CIC_BIT_GLOBAL_EN   7
`define CIC_BIT_PERIPH_EN   6
`define CIC_BIT_TIMER_EN    5
`define CIC_BIT_EXT_EN      4
`define CIC_BIT_CHANGE_EN   3
`define CIC_BIT_TIMER_FLAG  2
`define CIC_BIT_EXT_FLAG    1
`define CIC_BIT_CHANGE_FLAG 0

// Port E pin 3 is the only implemented edge-enable bit
`define CIC_BIT_PORT_E3     3

// Status bits of the wrapper interrupt register
`define CIC_EVT_TIMER       0
`define CIC_EVT_EXT         1
`define CIC_EVT_CHANGE      2

// ----------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------
`define CIC_RST_CONTROL     8'h00
`define CIC_RST_EDGE_EN     8'h00
`define CIC_PERIPH_SRCS     8

`endif

// *** rtl/cic_pkg.sv ***
// Purpose: Types shared by the interrupt control block.
// Assumes: Nothing beyond the configuration header.
// Notes:   Types only; numbers live in cic_cfg.svh.
package cic_pkg;

    // APB transfer phase
    typedef enum logic [1:0] {
        CIC_IDLE   = 2'b00,
        CIC_SETUP  = 2'b01,
        CIC_ACCESS = 2'b10
    } cic_phase_type;

    typedef logic [7:0]  cic_byte_type;
    typedef logic [31:0] cic_word_type;

endpackage : cic_pkg

// *** bench/cic_core_sva.sv ***
// Purpose: Port-level checker for the interrupt control block.
// Assumes: Zero-wait APB; mirrors of enables and mask kept from write traffic.
// Notes:   Bound to cic_core at the foot of this file.
`timescale 1ns/10ps
`include "cic_cfg.svh"
module cic_core_sva
    import cic_pkg::*;
(
    input wire logic                  ref_clk,        // System clock
    input wire logic                  rst_n,          // Async reset, low
    input wire logic                  psel,           // APB select
    input wire logic                  penable,        // APB enable
    input wire logic                  pwrite,         // APB direction
    input wire logic [11:0]           paddr,          // APB address
    input wire cic_pkg::cic_word_type pwdata,         // APB write data
    input wire logic [3:0]            pstrb,          // APB strobes
    input wire logic                  pready,         // APB ready
    input wire cic_pkg::cic_word_type prdata,         // APB read data
    input wire logic                  pslverr,        // APB error
    input wire logic                  timer_overflow, // Timer wrap
    input wire logic                  ext_pin_event,  // External event
    input wire logic                  port_e3_pin,    // Pin level
    input wire logic [7:0]            periph_event,   // Peripheral events
    input wire logic                  core_irq,       // Core request
    input wire logic                  irq             // Status irq
);
    // ------------------------------------------------------------------
    // Mirrors of written control state
    // ------------------------------------------------------------------
    logic [7:0] ctl_q, ctl_d;
    logic [2:0] msk_q, msk_d;
    logic       rise_q, rise_d;
    logic       acc, wr;
    // Writes land only at the access edge, as in the block itself
    assign acc    = psel && penable && pready;
    assign wr     = acc && pwrite && pstrb[0];
    assign ctl_d  = (wr && paddr == `CIC_OFS_INTERRUPT_CONTROL) ? pwdata[7:0] : ctl_q;
    assign msk_d  = (wr && paddr == `CIC_OFS_IRQ_MASK) ? pwdata[2:0] : msk_q;
    assign rise_d = (wr && paddr == `CIC_OFS_RISE_ENABLE) ? pwdata[3] : rise_q;
    // Mirror registers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_q  <= 8'h00;
            msk_q  <= 3'h0;
            rise_q <= 1'b0;
        end
        else
        begin
            ctl_q  <= ctl_d;
            msk_q  <= msk_d;
            rise_q <= rise_d;
        end
    end
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_setup;
        psel && !penable;
    endsequence
    // Enables must hold one cycle past the event, else the flag wins alone
    sequence s_ext_armed;
        ext_pin_event && ctl_q[7] && ctl_q[4] ##1 ctl_q[7] && ctl_q[4];
    endsequence
    chk_ready_setup: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    chk_err_unmapped: assert property (s_setup ##0 (paddr > `CIC_OFS_IRQ_MASK)
        |=> pslverr && (pwrite || prdata == '0)) else $error("unmapped not refused");
    chk_gie_blocks: assert property (!ctl_q[7] && !$past(ctl_q[7]) |-> !core_irq)
        else $error("core request with global enable off");
    chk_timer_irq: assert property (timer_overflow && msk_q[0] ##1 msk_q[0]
        |-> ##[1:2] irq) else $error("timer event gave no irq");
    chk_ext_core: assert property (s_ext_armed |-> ##[1:2] core_irq)
        else $error("enabled pin event gave no core request");
    chk_pin_irq: assert property ($rose(port_e3_pin) && rise_q && msk_q[2]
        ##1 msk_q[2] |-> ##[1:3] irq) else $error("rising edge gave no irq");
    chk_edge_zero: assert property (acc && !pwrite && paddr == `CIC_OFS_RISE_ENABLE
        |-> prdata[7:4] == 4'h0 && prdata[2:0] == 3'h0) else $error("reserved bits set");
endmodule : cic_core_sva

bind cic_core cic_core_sva u_sva (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .timer_overflow(timer_overflow),
    .ext_pin_event(ext_pin_event), .port_e3_pin(port_e3_pin), .periph_event(periph_event),
    .core_irq(core_irq), .irq(irq));

// *** bench/cic_core_model.sv ***
// Purpose: Processor core side that takes the interrupt request.
// Assumes: Level request; one take per rising request.
// Notes:   Counts takes so the bench can see spurious or lost requests.
`timescale 1ns/10ps
module cic_core_model
(
    input wire logic  ref_clk,    // System clock
    input wire logic  rst_n,      // Async reset, low
    input wire logic  core_irq,   // Request from block
    output logic [7:0] take_count // Requests taken
);
    logic       seen_q;
    logic [7:0] take_d;
    // A held level is one request, not one per cycle
    assign take_d = (core_irq && !seen_q) ? take_count + 8'h01 : take_count;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seen_q     <= 1'b0;
            take_count <= 8'h00;
        end
        else
        begin
            seen_q     <= core_irq;
            take_count <= take_d;
        end
    end
endmodule : cic_core_model

// *** bench/tb.sv ***
// Purpose: Register-level tests of the interrupt control block.
// Assumes: Zero-wait APB slave; events are one-cycle pulses.
// Notes:   Expected values come from the field layout only.
`timescale 1ns/10ps
`include "cic_cfg.svh"
module tb;
    import cic_pkg::*;
    localparam logic [11:0] a_ctl = `CIC_OFS_INTERRUPT_CONTROL;
    localparam logic [11:0] a_rise = `CIC_OFS_RISE_ENABLE;
    localparam logic [11:0] a_fall = `CIC_OFS_FALL_ENABLE;
    localparam logic [11:0] a_chg = `CIC_OFS_CHANGE_FLAG;
    localparam logic [11:0] a_pen = `CIC_OFS_PERIPH_ENABLE;
    localparam logic [11:0] a_sts = `CIC_OFS_IRQ_STATUS;
    localparam logic [11:0] a_msk = `CIC_OFS_IRQ_MASK;
    logic         ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, err_q;
    logic         timer_overflow, ext_pin_event, port_e3_pin, core_irq, irq;
    logic [11:0]  paddr;
    logic [3:0]   pstrb;
    logic [7:0]   periph_event, take_count;
    cic_word_type pwdata, prdata, rd_q;
    int           err_count, cmp_count;
    cic_core dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .timer_overflow(timer_overflow),
        .ext_pin_event(ext_pin_event), .port_e3_pin(port_e3_pin),
        .periph_event(periph_event), .core_irq(core_irq), .irq(irq));
    cic_core_model u_core (.ref_clk(ref_clk), .rst_n(rst_n), .core_irq(core_irq),
        .take_count(take_count));
    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task end_sim;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task check(input string nm, input cic_word_type seen, input cic_word_type exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // One APB transfer; request held until pready is seen at an edge
    task apb(input logic w, input logic [11:0] a, input cic_word_type d);
        int n;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            err_count++;
            end_sim();
        end
        rd_q    = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rd(input logic [11:0] a, input cic_word_type exp, input string nm);
        apb(1'b0, a, 32'h0);
        check(nm, rd_q, exp);
    endtask : rd
    // Bit 0 timer, bit 1 external pin, bit 2 peripheral 0
    task fire(input logic [2:0] s);
        @(posedge ref_clk);
        timer_overflow <= s[0];
        ext_pin_event  <= s[1];
        periph_event   <= {7'h00, s[2]};
        @(posedge ref_clk);
        timer_overflow <= 1'b0;
        ext_pin_event  <= 1'b0;
        periph_event   <= 8'h00;
        repeat (3) @(posedge ref_clk);
    endtask : fire
    task pin(input logic v);
        @(posedge ref_clk);
        port_e3_pin <= v;
        repeat (3) @(posedge ref_clk);
    endtask : pin
    // ------------------------------------------------------------------
    // Clock, watchdog and test sequence
    // ------------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Hang guard; far above the length of the sequence
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        end_sim();
    end
    initial
    begin
        {rst_n, psel, penable, pwrite, timer_overflow, ext_pin_event, port_e3_pin} = 7'h00;
        {paddr, pwdata, periph_event, err_count, cmp_count} = '0;
        pstrb = 4'hF;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(a_rise, 32'h0, "rise reset");
        apb(1'b1, a_rise, 32'hFFFF_FFFF);
        rd(a_rise, 32'h0000_0008, "rise bits");
        apb(1'b1, a_fall, 32'hFFFF_FFFF);
        rd(a_fall, 32'h0000_0008, "fall bits");
        rd(12'h040, 32'h0, "unmapped data");
        check("unmapped err", 32'(err_q), 32'h1);
        $display("test registers done");
        apb(1'b1, a_rise, 32'h0);
        apb(1'b1, a_fall, 32'h0);
        pin(1'b1);
        pin(1'b0);
        rd(a_chg, 32'h0, "no edge enable");
        fire(3'b011);
        rd(a_ctl, 32'h06, "flags no enable");
        check("core off", 32'(core_irq), 32'h0);
        apb(1'b1, a_ctl, 32'h0);
        rd(a_ctl, 32'h0, "flags cleared");
        apb(1'b1, a_rise, 32'h08);
        pin(1'b1);
        rd(a_ctl, 32'h01, "rise summary");
        rd(a_chg, 32'h08, "rise pin flag");
        apb(1'b1, a_ctl, 32'h0);
        rd(a_ctl, 32'h01, "summary held");
        apb(1'b1, a_chg, 32'h0);
        rd(a_ctl, 32'h0, "summary clears");
        apb(1'b1, a_rise, 32'h0);
        apb(1'b1, a_fall, 32'h08);
        pin(1'b0);
        rd(a_ctl, 32'h01, "fall summary");
        apb(1'b1, a_chg, 32'h0);
        pin(1'b1);
        rd(a_ctl, 32'h0, "rise ignored");
        $display("test flags done");
        apb(1'b1, a_sts, 32'h07);
        apb(1'b1, a_msk, 32'h07);
        fire(3'b001);
        check("irq timer", 32'(irq), 32'h1);
        apb(1'b1, a_sts, 32'h01);
        repeat (2) @(posedge ref_clk);
        check("irq cleared", 32'(irq), 32'h0);
        apb(1'b1, a_msk, 32'h0);
        pstrb <= 4'hE;
        apb(1'b1, a_msk, 32'h07);
        pstrb <= 4'hF;
        rd(a_msk, 32'h0, "strobe off");
        fire(3'b010);
        check("irq masked", 32'(irq), 32'h0);
        rd(a_sts, 32'h02, "status ext");
        apb(1'b1, a_msk, 32'h04);
        pin(1'b0);
        check("irq fall", 32'(irq), 32'h1);
        apb(1'b1, a_sts, 32'h04);
        apb(1'b1, a_rise, 32'h08);
        pin(1'b1);
        check("irq rise", 32'(irq), 32'h1);
        $display("test irq done");
        apb(1'b1, a_ctl, 32'h0);
        apb(1'b1, a_ctl, 32'h90);
        fire(3'b010);
        check("core ext", 32'(core_irq), 32'h1);
        check("core takes", 32'(take_count), 32'h1);
        apb(1'b1, a_ctl, 32'h12);
        repeat (2) @(posedge ref_clk);
        check("core gated", 32'(core_irq), 32'h0);
        apb(1'b1, a_ctl, 32'h0);
        apb(1'b1, a_pen, 32'h01);
        apb(1'b1, a_ctl, 32'h80);
        fire(3'b100);
        check("periph gated", 32'(core_irq), 32'h0);
        apb(1'b1, a_ctl, 32'hC0);
        repeat (2) @(posedge ref_clk);
        check("periph core", 32'(core_irq), 32'h1);
        apb(1'b1, a_ctl, 32'h80);
        repeat (2) @(posedge ref_clk);
        check("change gated", 32'(core_irq), 32'h0);
        apb(1'b1, a_ctl, 32'h88);
        repeat (2) @(posedge ref_clk);
        check("change core", 32'(core_irq), 32'h1);
        apb(1'b1, a_ctl, 32'hA0);
        fire(3'b001);
        check("core timer", 32'(core_irq), 32'h1);
        $display("test core request done");
        end_sim();
    end
endmodule : tb
